//--- rtl/rcs_clock_ctrl.sv
// Purpose: reference clock source select, start-up delay and clock gate
// Assumes: raw clocks arrive as sampled levels on clk; qualifiers are inputs
// Notes: all outputs registered; gate output is the registered level of the gated raw clock
//
// The register offsets and strobed register access were decided locally.
`timescale 1ns/1ns
module rcs_clock_ctrl
    import rcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic osc_raw_clk,
    input wire logic crystal_pin_two,
    input wire logic osc_amplitude_ok,
    input wire logic clk_shape_ok,
    output logic osc_enable_int,
    output logic ext_buffer_on,
    output logic core_clk,
    output logic refclk_valid,
    output logic ptcal_start,
    output logic clock_observe_pin
);
    import rcs_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] expert;
        logic [7:0] rdata;
        logic [3:0] sync1;
        logic [3:0] sync2;
        logic osc_en;
        logic ext_en;
        logic raw_q;
        rcs_state_e state;
        logic [RCS_CNT_W-1:0] cnt;
        logic valid;
        logic core_clk;
        logic ptcal;
        logic obs;
    } rcs_s;

    rcs_s st_reg, st_next;

    function automatic logic [RCS_CNT_W-1:0] rcs_term(input logic [1:0] sel);
        case (sel)
            2'h0: rcs_term = RCS_DLY_0;
            2'h1: rcs_term = RCS_DLY_1;
            2'h2: rcs_term = RCS_DLY_2;
            default: rcs_term = RCS_DLY_3;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////
    logic pd_s, dis_s, ext_s, force_s;
    logic raw_clk, raw_rise, amp_ok, run_delay;

    always_comb
    begin
        pd_s = st_reg.sync2[0];
        dis_s = st_reg.sync2[1];
        ext_s = st_reg.sync2[2];
        force_s = st_reg.sync2[3];
        // disabled sources contribute zero, so an or merges them
        raw_clk = (st_reg.osc_en & osc_raw_clk) | (st_reg.ext_en & crystal_pin_two); // RL5 RL6
        raw_rise = raw_clk & ~st_reg.raw_q;
        amp_ok = st_reg.osc_en ? (osc_amplitude_ok | force_s) : st_reg.ext_en; // RL8 RL9
        run_delay = st_reg.osc_en | (st_reg.ext_en & force_s); // RL14 RL16
    end

    always_comb
    begin
        st_next = st_reg;
        st_next.ptcal = 1'b0;
        st_next.rdata = 8'h00;
        if (wr)
        begin
            if (addr == RCS_ADDR_CTRL)
                st_next.ctrl = wdata;
            if (addr == RCS_ADDR_EXPERT)
                st_next.expert = wdata;
        end
        if (rd)
        begin
            case (addr)
                RCS_ADDR_CTRL: st_next.rdata = st_reg.ctrl;
                RCS_ADDR_EXPERT: st_next.rdata = st_reg.expert;
                RCS_ADDR_STATUS: st_next.rdata = {4'h0, st_reg.ext_en, st_reg.osc_en, st_reg.valid,
                    osc_amplitude_ok};
                default: st_next.rdata = 8'h00;
            endcase
        end
        st_next.sync1 = {st_reg.expert[RCS_EXP_FORCE], st_reg.ctrl[RCS_CTRL_EXT_EN],
            st_reg.ctrl[RCS_CTRL_OSC_DIS], st_reg.ctrl[RCS_CTRL_PWRDN]}; // RL20
        st_next.sync2 = st_reg.sync1; // RL20
        st_next.osc_en = ~pd_s & ~dis_s; // RL1 RL3
        st_next.ext_en = ~pd_s & dis_s & ext_s; // RL2 RL3
        st_next.raw_q = raw_clk;
        case (st_reg.state)
            RCS_OFF:
            begin
                st_next.cnt = '0; // RL8
                st_next.valid = 1'b0;
                if (amp_ok)
                    st_next.state = RCS_WAIT; // RL9
            end
            RCS_WAIT:
            begin
                if (!run_delay)
                begin
                    st_next.valid = 1'b1; // RL14
                    st_next.state = RCS_RUN;
                end
                else if (st_reg.cnt >= rcs_term(st_reg.expert[RCS_EXP_DLY_LO +: 2]))
                begin
                    st_next.valid = 1'b1; // RL11 RL12
                    st_next.state = RCS_RUN;
                end
                else if (raw_rise && clk_shape_ok)
                    st_next.cnt = st_reg.cnt + 1'b1; // RL9 RL10
            end
            RCS_RUN:
                st_next.valid = 1'b1;
            default:
                st_next.state = RCS_OFF;
        endcase
        if (!amp_ok || pd_s)
        begin
            st_next.state = RCS_OFF; // RL13 RL3
            st_next.valid = 1'b0; // RL13
            st_next.cnt = '0;
        end
        st_next.ptcal = st_next.valid & ~st_reg.valid; // RL19
        // gate only opens on the pulse after valid; low clock holds output low
        st_next.core_clk = st_reg.valid & raw_clk; // RL4 RL7 RL12
        st_next.obs = st_reg.ctrl[RCS_CTRL_OBS_SEL] ? osc_amplitude_ok : st_reg.valid; // RL17
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st_reg <= '0;
            st_reg.ctrl <= RCS_CTRL_RESET;
            st_reg.expert <= RCS_EXP_RESET;
            st_reg.sync1 <= 4'h1;
            st_reg.sync2 <= 4'h1;
            st_reg.state <= RCS_OFF;
        end
        else if (ce)
            st_reg <= st_next;
    end

    assign rdata = st_reg.rdata;
    assign osc_enable_int = st_reg.osc_en;
    assign ext_buffer_on = st_reg.ext_en;
    assign core_clk = st_reg.core_clk;
    assign refclk_valid = st_reg.valid;
    assign ptcal_start = st_reg.ptcal;
    assign clock_observe_pin = st_reg.obs;

    ////////////////////////////////////////////////////////////////////////
    chk_osc_en_cond: assert property (@(posedge clk) disable iff (!rst_n) // RL1
        ce |=> (osc_enable_int == ($past(~pd_s & ~dis_s))))
        else $error("oscillator enable wrong");
    chk_ext_en_cond: assert property (@(posedge clk) disable iff (!rst_n) // RL2
        ce |=> (ext_buffer_on == ($past(~pd_s & dis_s & ext_s))))
        else $error("external buffer enable wrong");
    chk_src_exclusive: assert property (@(posedge clk) disable iff (!rst_n) // RL3
        !(osc_enable_int && ext_buffer_on))
        else $error("both sources enabled");
    chk_gate_closed: assert property (@(posedge clk) disable iff (!rst_n) // RL7
        core_clk |-> $past(refclk_valid))
        else $error("gate passed clock while invalid");
    chk_valid_drop: assert property (@(posedge clk) disable iff (!rst_n) // RL13
        (ce && refclk_valid && !amp_ok) |=> !refclk_valid)
        else $error("valid not cleared on clock loss");
    chk_cnt_reset: assert property (@(posedge clk) disable iff (!rst_n) // RL8
        (ce && (pd_s || !amp_ok)) |=> (st_reg.cnt == '0))
        else $error("counter not held in reset");
    chk_cnt_shape: assert property (@(posedge clk) disable iff (!rst_n) // RL10
        (ce && !clk_shape_ok && st_reg.state == RCS_WAIT) |=> (st_reg.cnt <= $past(st_reg.cnt)))
        else $error("counter advanced on bad clock");
    chk_ptcal_pulse: assert property (@(posedge clk) disable iff (!rst_n) // RL19
        $rose(refclk_valid) |-> ptcal_start)
        else $error("recalibration not started");
    chk_bypass: assert property (@(posedge clk) disable iff (!rst_n) // RL14
        (ce && st_reg.state == RCS_WAIT && !run_delay && amp_ok && !pd_s) |=> refclk_valid)
        else $error("bypass did not set valid");

    chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n) // RL17
        (ce && !rd) |=> (rdata == 8'h00))
        else $error("read data not idle");

    chk_obs_route: assert property (@(posedge clk) disable iff (!rst_n) // RL17
        ce |=> (clock_observe_pin == $past(st_reg.ctrl[RCS_CTRL_OBS_SEL] ? osc_amplitude_ok : refclk_valid)))
        else $error("observe pin wrong");

    chk_src_off_zero: assert property (@(posedge clk) disable iff (!rst_n) // RL5
        (ce && !osc_enable_int && !ext_buffer_on) |=> !core_clk)
        else $error("clock passed with sources off");

    chk_ce_freeze: assert property (@(posedge clk) disable iff (!rst_n) // RL4
        !ce |=> ($stable(refclk_valid) && $stable(core_clk)))
        else $error("state moved while frozen");

    chk_cnt_stop: assert property (@(posedge clk) disable iff (!rst_n) // RL11
        (ce && st_reg.state == RCS_RUN && amp_ok && !pd_s) |=> $stable(st_reg.cnt))
        else $error("counter moved after end of delay");
endmodule

//--- rtl/rcs_pkg.sv
// Purpose: constants for the reference clock start-up control
// Assumes: one system clock stands in for the raw oscillator clock
// Notes: register bus offsets and field positions live here
//
// Notes on behaviour
// [RL1] crystal on: powered up, oscillator not disabled
// [RL2] external buffer on: powered, disabled, buffer enabled
// [RL3] power-down stops clocks; crystal has priority
// [RL4] source switching passes glitch-free transition control
// [RL5] disabled source output held at zero
// [RL6] external mode takes clock from pin two
// [RL7] raw clock passes only through enabled gate
// [RL8] delay counter reset without amplitude or force
// [RL9] amplitude ok or force releases counter
// [RL10] no counting on low amplitude or thin pulses
// [RL11] terminal count from two-bit select field
// [RL12] end-of-delay sampled into valid, opens gate
// [RL13] valid clears at once when clock lost
// [RL14] external mode without force bypasses counter
// [RL15] external source stable, near half duty
// [RL16] force in external mode applies delay counting
// [RL17] amplitude ok and valid observable on pins
// [RL18] software sets force for low-Q resonators
// [RL19] valid assertion starts polling timer recalibration
// [RL20] config inputs synchronised before use; the delay select and observe select bits are used unsynchronised
package rcs_pkg;
    localparam logic [3:0] RCS_ADDR_CTRL = 4'h0;
    localparam logic [3:0] RCS_ADDR_EXPERT = 4'h1;
    localparam logic [3:0] RCS_ADDR_STATUS = 4'h2;
    localparam int RCS_CTRL_PWRDN = 0;
    localparam int RCS_CTRL_OSC_DIS = 1;
    localparam int RCS_CTRL_EXT_EN = 2;
    localparam int RCS_CTRL_OBS_SEL = 3;
    localparam int RCS_EXP_DLY_LO = 0;
    localparam int RCS_EXP_FORCE = 2;
    localparam logic [7:0] RCS_CTRL_RESET = 8'h01;
    localparam logic [7:0] RCS_EXP_RESET = 8'h00;
    localparam int RCS_CNT_W = 12;
    localparam logic [11:0] RCS_DLY_0 = 12'h040;
    localparam logic [11:0] RCS_DLY_1 = 12'h100;
    localparam logic [11:0] RCS_DLY_2 = 12'h400;
    localparam logic [11:0] RCS_DLY_3 = 12'hfff;
    typedef enum logic [1:0] {RCS_OFF, RCS_WAIT, RCS_RUN} rcs_state_e;
endpackage

//--- test/rcs_clk_src.sv
// Purpose: crystal and external clock source model
// Assumes: raw clocks are levels toggled on clk
// Notes: amplitude is reported some cycles after enable
`timescale 1ns/1ns
module rcs_clk_src (
    input wire logic clk,
    input wire logic osc_enable_int,
    input wire logic ext_buffer_on,
    input wire logic amp_kill,
    output logic osc_raw_clk,
    output logic crystal_pin_two,
    output logic osc_amplitude_ok,
    output logic clk_shape_ok
);
    logic [3:0] settle = 4'h0;
    initial osc_raw_clk = 1'b0;
    initial crystal_pin_two = 1'b0;
    always @(posedge clk)
    begin
        crystal_pin_two <= !crystal_pin_two;
        settle <= (osc_enable_int && !amp_kill) ? settle + {3'h0, settle != 4'hf} : 4'h0;
        osc_raw_clk <= (osc_enable_int && !amp_kill) ? !osc_raw_clk : 1'b0;
    end
    assign osc_amplitude_ok = settle > 4'h8;
    assign clk_shape_ok = osc_amplitude_ok || ext_buffer_on;
endmodule

//--- test/rcs_clock_ctrl_tb_top.sv
// Purpose: self-checking bench for the clock start-up control
// Assumes: ce held high except during the freeze check in test_force; the source model drives the clock side
// Notes: delay expectations follow the first two terminal counts
`timescale 1ns/1ns
module rcs_clock_ctrl_tb_top;
    import rcs_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ce = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic amp_kill = 1'b0;
    logic prev;
    logic [7:0] rdata;
    logic osc_raw_clk, crystal_pin_two, osc_amplitude_ok, clk_shape_ok, osc_enable_int, ext_buffer_on;
    logic core_clk, refclk_valid, ptcal_start, clock_observe_pin;
    int num_errors = 0;
    int compares = 0;
    rcs_clock_ctrl uut (.clk, .rst_n, .ce, .addr, .wdata, .wr, .rd, .rdata, .osc_raw_clk, .crystal_pin_two,
        .osc_amplitude_ok, .clk_shape_ok, .osc_enable_int, .ext_buffer_on, .core_clk, .refclk_valid,
        .ptcal_start, .clock_observe_pin);
    rcs_clk_src src (.clk, .osc_enable_int, .ext_buffer_on, .amp_kill, .osc_raw_clk, .crystal_pin_two,
        .osc_amplitude_ok, .clk_shape_ok);
    initial
    begin
        forever #25 clk = !clk;
    end
////////////////////////////////////////////////////////////////////////////////
    task check(input logic [7:0] got, input logic [7:0] exp, input string msg);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("FAIL %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask
    task conclude;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task rd_reg(input logic [3:0] a, input logic [7:0] exp);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        check(rdata, exp, "register read");
    endtask
    // bounded wait for the ready flag, a run-out ends the run
    task wait_valid(input logic v, input int n);
        for (int i = 0; i < n && refclk_valid !== v; i++)
            tick(1);
        check({7'h0, refclk_valid}, {7'h0, v}, "ready wait");
        if (refclk_valid !== v)
            conclude();
    endtask
////////////////////////////////////////////////////////////////////////////////
    task test_reset;
        #1;
        check({4'h0, osc_enable_int, ext_buffer_on, refclk_valid, core_clk}, 8'h00, "power-down outputs");
        rd_reg(RCS_ADDR_CTRL, RCS_CTRL_RESET);
        rd_reg(RCS_ADDR_EXPERT, RCS_EXP_RESET);
        rd_reg(4'hf, 8'h00);
        $display("done reset");
    endtask
    task test_crystal;
        wr_reg(RCS_ADDR_CTRL, 8'h08);
        tick(4);
        check({6'h0, osc_enable_int, ext_buffer_on}, 8'h02, "crystal enable");
        tick(100);
        check({6'h0, refclk_valid, core_clk}, 8'h00, "early ready");
        wait_valid(1'b1, 200);
        check({7'h0, ptcal_start}, 8'h01, "recal pulse");
        check({7'h0, clock_observe_pin}, 8'h01, "observe amplitude");
        rd_reg(RCS_ADDR_STATUS, 8'h07);
        amp_kill <= 1'b1;
        wait_valid(1'b0, 6);
        amp_kill <= 1'b0;
        $display("done crystal");
    endtask
    task test_ext;
        wr_reg(RCS_ADDR_CTRL, 8'h06);
        wait_valid(1'b1, 10);
        check({6'h0, osc_enable_int, ext_buffer_on}, 8'h01, "buffer enable");
        tick(1);
        prev = core_clk;
        tick(1);
        check({7'h0, core_clk}, {7'h0, !prev}, "gated clock");
        wr_reg(RCS_ADDR_CTRL, 8'h07);
        tick(6);
        check({4'h0, osc_enable_int, ext_buffer_on, refclk_valid, core_clk}, 8'h00, "stop");
        $display("done external");
    endtask
    task test_force;
        wr_reg(RCS_ADDR_EXPERT, 8'h05);
        wr_reg(RCS_ADDR_CTRL, 8'h06);
        tick(300);
        check({7'h0, refclk_valid}, 8'h00, "forced delay");
        wait_valid(1'b1, 400);
        ce <= 1'b0;
        tick(1);
        prev = core_clk;
        tick(4);
        check({6'h0, refclk_valid, core_clk}, {6'h0, 1'b1, prev}, "frozen");
        ce <= 1'b1;
        $display("done force");
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        test_reset();
        test_crystal();
        test_ext();
        test_force();
        conclude();
    end
endmodule
